/* verilog/wdg_pkg.sv */
// Package: constants, register map and types for the watchdog block
`default_nettype none
package wdg_pkg;
  // ----------------------------------------------------------------
  // Register map: printed offsets are indices, byte address is 4x
  // ----------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam logic [15:0] IDX_CONFIG = 16'h0000;
  localparam logic [15:0] IDX_STATUS = 16'h0001;
  localparam logic [15:0] IDX_SERVICE = 16'hffff;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = {IDX_CONFIG, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_SERVICE = {IDX_SERVICE, 2'b00};

  // ----------------------------------------------------------------
  // Configuration field positions and value after reset
  // ----------------------------------------------------------------
  localparam int CFG_WDG_DISABLE = 0;
  localparam int CFG_STOP_ENABLE = 1;
  localparam int CFG_TIMEOUT_SEL = 2;
  localparam int CFG_SHORT_RECOV = 3;
  localparam int CFG_LVM_POWER = 4;
  localparam int CFG_LVM_RESET = 5;
  localparam int CFG_LVM_STOP = 6;
  localparam logic [7:0] CFG_RESET_VAL = 8'h00;

  // Status field positions
  localparam int STS_WDG_FLAG = 0;
  localparam int STS_LVM_FLAG = 1;
  localparam int STS_CFG_LOCKED = 2;

  // ----------------------------------------------------------------
  // Timing, in oscillator cycles (oscillator clock is pclk)
  // ----------------------------------------------------------------
  localparam int CNT_W = 6;
  localparam int SHORT_TAP_W = 7;
  localparam int TIMEOUT_SHORT_CYC = 8176;
  localparam int TIMEOUT_LONG_CYC = 262128;
  localparam int TIMEOUT_TRIM_CYC = (2 ** 18) - TIMEOUT_LONG_CYC;
  localparam int RECOV_SHORT_CYC = 32;
  localparam int RECOV_LONG_CYC = 4096;
  localparam int RST_PULSE_CYC = 32;
  localparam int POR_CLEAR_CYC = 4096;
  localparam int SVC_CLEAR_LSB = 3;
  localparam logic [7:0] RESET_VECTOR_LO = 8'h00;

  // Stop-mode sequencing
  typedef enum logic [1:0] {
    WDG_RUN = 2'b00,
    WDG_STOPPED = 2'b01,
    WDG_RECOVER = 2'b10
  } wdg_stop_e;
endpackage
`default_nettype wire

/* verilog/wdg_top.sv */
// Watchdog with write-once system option configuration and APB access
//
// Added by the designer: the APB slave port.
`default_nettype none
// Function
// RULE_01: Configuration reads default after reset, takes first write only.
// RULE_02: Voltage monitor stays on in stop only if power and stop enables set.
// RULE_03: Reset enable gates the voltage monitor reset request.
// RULE_04: Power enable switches the voltage monitor on or off.
// RULE_05: Stop recovery delay is 32 cycles when set, 4096 when clear.
// RULE_06: Timeout select gives 8176 cycles when set, 262128 when clear.
// RULE_07: STOP with stop enable clear is an illegal opcode.
// RULE_08: Watchdog disable bit turns the watchdog off.
// RULE_09: Six-bit counter fed by twelve-bit prescaler; overflow causes reset.
// RULE_10: Service write clears counter and prescaler stages 4 to 12.
// RULE_11: Service read returns the reset vector low byte.
// RULE_12: Overflow pulls reset pin low 32 cycles and sets watchdog flag.
// RULE_13: Stop mode freezes the watchdog and clears its prescaler.
// RULE_14: Power-on logic clears the prescaler 4096 cycles after power-up.
// RULE_15: Internal reset clears prescaler and counter.
// RULE_16: Reset vector fetch clears the prescaler.
// RULE_17: Monitor mode with test voltage on reset or irq pin holds watchdog off.
// RULE_18: Break with test voltage on reset pin holds watchdog off.
// RULE_19: Watchdog keeps counting in wait mode.
// RULE_20: Watchdog never raises an interrupt request.
// RULE_21: Software should service after reset and around stop mode.
// RULE_22: Reset request asserts in the cycle the counter wraps from all ones.
module wdg_top #(
  parameter int PRE_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wdg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_instr,
  input wire logic stop_wake,
  input wire logic vector_fetch,
  input wire logic internal_reset,
  input wire logic monitor_mode,
  input wire logic break_active,
  input wire logic rst_pin_test_voltage,
  input wire logic irq_pin_test_voltage,
  input wire logic lvm_trip,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  output logic system_reset,
  output logic lvm_power,
  output logic lvm_reset,
  output logic illegal_opcode,
  output logic stop_active
);
  import wdg_pkg::*;

  localparam logic [PRE_W-1:0] PRE_ONES = {PRE_W{1'b1}};
  localparam logic [PRE_W-1:0] LONG_END = PRE_ONES - PRE_W'(TIMEOUT_TRIM_CYC);
  localparam logic [SHORT_TAP_W-1:0] SHORT_ONES = {SHORT_TAP_W{1'b1}};
  localparam logic [SHORT_TAP_W-1:0] SHORT_END = SHORT_ONES - SHORT_TAP_W'(TIMEOUT_TRIM_CYC);
  localparam logic [11:0] RECOV_SHORT_LD = 12'(RECOV_SHORT_CYC - 1);
  localparam logic [11:0] RECOV_LONG_LD = 12'(RECOV_LONG_CYC - 1);
  localparam logic [5:0] PULSE_LD = 6'(RST_PULSE_CYC - 1);
  localparam logic [12:0] POR_LAST = 13'(POR_CLEAR_CYC - 1);

  logic [7:0] cfg_q;
  logic cfg_locked_q;
  logic [PRE_W-1:0] pre_q;
  logic [CNT_W-1:0] cnt_q;
  logic [5:0] pulse_cnt_q;
  logic pulse_q;
  logic [11:0] recov_cnt_q;
  logic [12:0] por_cnt_q;
  logic por_done_q;
  logic wdg_flag_q;
  logic lvm_flag_q;
  wdg_stop_e stop_st_q;

  logic acc;
  logic wr_en;
  logic rd_setup;
  logic hit_cfg;
  logic hit_sts;
  logic hit_svc;
  logic svc_write;
  logic sts_read;
  logic held_off;
  logic wdg_run;
  logic tap_full;
  logic [SHORT_TAP_W-1:0] pre_low;
  logic at_end;
  logic wdg_fire;
  logic por_clear;
  logic int_clear;
  logic stop_enter;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Zero wait states; read data is captured in the setup cycle
  assign acc = psel && penable;
  assign wr_en = acc && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign hit_cfg = (paddr == ADDR_CONFIG);
  assign hit_sts = (paddr == ADDR_STATUS);
  assign hit_svc = (paddr == ADDR_SERVICE);
  assign pready = 1'b1;
  assign pslverr = acc && !(hit_cfg || hit_sts || hit_svc);
  assign svc_write = wr_en && hit_svc;
  assign sts_read = acc && !pwrite && hit_sts;

  // Read mux registered in setup so data is stable through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      if (hit_cfg) begin
        prdata <= {24'h00_0000, cfg_q};
      end else if (hit_sts) begin
        prdata <= {29'h0000_0000, cfg_locked_q, lvm_flag_q, wdg_flag_q};
      end else if (hit_svc) begin
        prdata <= {24'h00_0000, RESET_VECTOR_LO}; // RULE_11
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write-once configuration
  // ----------------------------------------------------------------
  // Lock stops runaway code from disabling the watchdog later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_RESET_VAL; // RULE_01
      cfg_locked_q <= 1'b0;
    end else if (wr_en && hit_cfg && !cfg_locked_q) begin
      cfg_q <= pwdata[7:0]; // RULE_01
      cfg_locked_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Voltage monitor gating
  // ----------------------------------------------------------------
  assign lvm_power = cfg_q[CFG_LVM_POWER] // RULE_04
    && (stop_st_q == WDG_RUN || cfg_q[CFG_LVM_STOP]); // RULE_02
  assign lvm_reset = lvm_power && cfg_q[CFG_LVM_RESET] && lvm_trip; // RULE_03

  // ----------------------------------------------------------------
  // Stop mode sequencing
  // ----------------------------------------------------------------
  assign illegal_opcode = stop_instr && stop_st_q == WDG_RUN && !cfg_q[CFG_STOP_ENABLE]; // RULE_07
  assign stop_enter = stop_instr && stop_st_q == WDG_RUN && cfg_q[CFG_STOP_ENABLE];
  assign stop_active = (stop_st_q != WDG_RUN);

  // Recovery delay counts down from one less than the selected length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_st_q <= WDG_RUN;
      recov_cnt_q <= 12'h000;
    end else begin
      case (stop_st_q)
        WDG_RUN: begin
          if (stop_enter) begin
            stop_st_q <= WDG_STOPPED;
          end
        end
        WDG_STOPPED: begin
          if (stop_wake) begin
            stop_st_q <= WDG_RECOVER;
            recov_cnt_q <= cfg_q[CFG_SHORT_RECOV] ? RECOV_SHORT_LD : RECOV_LONG_LD; // RULE_05
          end
        end
        WDG_RECOVER: begin
          if (recov_cnt_q == 12'h000) begin
            stop_st_q <= WDG_RUN;
          end else begin
            recov_cnt_q <= recov_cnt_q - 12'h001;
          end
        end
        default: begin
          stop_st_q <= WDG_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Power-on prescaler clear
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_cnt_q <= 13'h0000;
      por_done_q <= 1'b0;
    end else if (!por_done_q) begin
      if (por_cnt_q == POR_LAST) begin
        por_done_q <= 1'b1;
      end
      por_cnt_q <= por_cnt_q + 13'h0001;
    end
  end
  assign por_clear = !por_done_q && por_cnt_q == POR_LAST; // RULE_14

  // ----------------------------------------------------------------
  // Watchdog counter and prescaler
  // ----------------------------------------------------------------
  assign held_off = (monitor_mode && (rst_pin_test_voltage || irq_pin_test_voltage)) // RULE_17
    || (break_active && rst_pin_test_voltage); // RULE_18
  // Wait mode is not an input: counting simply carries on through it
  assign wdg_run = !cfg_q[CFG_WDG_DISABLE] && !held_off && stop_st_q == WDG_RUN; // RULE_08 RULE_19
  assign int_clear = internal_reset || pulse_q; // RULE_15
  // Sized view of the short tap, so a narrow prescaler never selects past its top bit
  assign pre_low = SHORT_TAP_W'(pre_q);
  assign tap_full = cfg_q[CFG_TIMEOUT_SEL] ? (pre_low == SHORT_ONES) : (pre_q == PRE_ONES);
  // End point sits the trim short of a full wrap, matching the timeout figures
  assign at_end = cfg_q[CFG_TIMEOUT_SEL] ? (pre_low == SHORT_END) // RULE_06
    : (pre_q == LONG_END); // RULE_06
  assign wdg_fire = wdg_run && !int_clear && !svc_write && cnt_q == {CNT_W{1'b1}} && at_end; // RULE_22

  // Prescaler: cleared whole by stop, power-on, vector fetch, internal reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
    end else if (int_clear || por_clear || vector_fetch || stop_st_q == WDG_STOPPED) begin
      pre_q <= '0; // RULE_13 RULE_14 RULE_15 RULE_16
    end else if (svc_write) begin
      pre_q <= {{(PRE_W-SVC_CLEAR_LSB){1'b0}}, pre_q[SVC_CLEAR_LSB-1:0]}; // RULE_10
    end else if (wdg_run) begin
      pre_q <= pre_q + PRE_W'(1); // RULE_09
    end
  end

  // Counter: advances on each wrap of the selected prescaler tap, frozen while stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (int_clear || svc_write || wdg_fire) begin
      cnt_q <= '0; // RULE_10 RULE_15 RULE_22
    end else if (wdg_run && tap_full) begin
      cnt_q <= cnt_q + CNT_W'(1); // RULE_09
    end
  end

  // ----------------------------------------------------------------
  // Reset pulse and status flags
  // ----------------------------------------------------------------
  // Timeout drives the reset pin and system_reset and sets the watchdog flag; there is no interrupt path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_q <= 1'b0;
      pulse_cnt_q <= 6'h00;
    end else if (wdg_fire) begin
      pulse_q <= 1'b1; // RULE_12 RULE_20
      pulse_cnt_q <= PULSE_LD;
    end else if (pulse_q) begin
      if (pulse_cnt_q == 6'h00) begin
        pulse_q <= 1'b0;
      end else begin
        pulse_cnt_q <= pulse_cnt_q - 6'h01;
      end
    end
  end
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe = pulse_q; // RULE_12
  assign system_reset = pulse_q || lvm_reset;

  // Read clears; a set in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdg_flag_q <= 1'b0;
      lvm_flag_q <= 1'b0;
    end else begin
      wdg_flag_q <= wdg_fire || (wdg_flag_q && !sts_read); // RULE_12
      lvm_flag_q <= lvm_reset || (lvm_flag_q && !sts_read);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  cfg_once_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
    (cfg_locked_q && wr_en && hit_cfg) |=> $stable(cfg_q))
    else $error("config changed after first write");
  lvm_stop_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    (stop_active && lvm_power) |-> (cfg_q[CFG_LVM_POWER] && cfg_q[CFG_LVM_STOP]))
    else $error("monitor powered in stop without both enables");
  lvm_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
    lvm_reset |-> (cfg_q[CFG_LVM_RESET] && lvm_trip))
    else $error("monitor reset not gated by enable");
  lvm_off_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
    !cfg_q[CFG_LVM_POWER] |-> !lvm_power)
    else $error("monitor powered while disabled");
  recov_short_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
    (stop_st_q == WDG_STOPPED && stop_wake && cfg_q[CFG_SHORT_RECOV])
      |=> (stop_st_q == WDG_RECOVER)[*8] ##25 (stop_st_q == WDG_RUN))
    else $error("short recovery not 32 cycles");
  illegal_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    (stop_instr && !cfg_q[CFG_STOP_ENABLE] && !stop_active) |-> illegal_opcode ##1 !stop_active)
    else $error("disabled STOP not treated as illegal");
  disabled_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
    cfg_q[CFG_WDG_DISABLE] |=> $stable(cnt_q) && !$rose(rst_pin_oe))
    else $error("disabled watchdog still running");
  svc_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_10
    svc_write |=> (cnt_q == '0) && (pre_q[PRE_W-1:SVC_CLEAR_LSB] == '0))
    else $error("service write did not clear watchdog");
  pulse_len_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
    $rose(rst_pin_oe) |-> ##31 rst_pin_oe ##1 !rst_pin_oe)
    else $error("reset pulse not 32 cycles");
  stop_freeze_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_13
    (stop_st_q == WDG_STOPPED && !int_clear && !svc_write) |=> pre_q == '0 && $stable(cnt_q))
    else $error("watchdog not frozen in stop");
  held_off_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_17 RULE_18
    held_off |-> !wdg_fire ##1 ($stable(cnt_q) || cnt_q == '0))
    else $error("watchdog ran while held off");
  fire_wrap_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_22
    wdg_fire |-> cnt_q == {CNT_W{1'b1}} ##1 (cnt_q == '0 && rst_pin_oe && wdg_flag_q))
    else $error("fire not at counter wrap");
endmodule
`default_nettype wire

/* tb/tb_watchdog_with_write_once_config.sv */
// Self-checking testbench for the watchdog with write-once configuration
`default_nettype none
module tb_watchdog_with_write_once_config;
  timeunit 1ns;
  timeprecision 1ps;
  import wdg_pkg::*;
  // ----------------------------------------------------------------
  // Signals and design under test
  // ----------------------------------------------------------------
  localparam int PRE_W = 6;
  localparam int PER = (2 ** (PRE_W + 6)) - 16; // Shortened long period
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic e;
  logic pready, pslverr, rst_pin_o, rst_pin_oe, system_reset;
  logic lvm_power, lvm_reset, illegal_opcode, stop_active;
  logic stop_instr = 1'b0;
  logic stop_wake = 1'b0;
  logic lvm_trip = 1'b0;
  logic [5:0] hold = '0; // Vector fetch, monitor, break, reset tv, irq tv, internal reset
  int n_errors = 0;
  int compares = 0;

  wdg_top #(.PRE_W(PRE_W)) u_wdg_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_instr(stop_instr), .stop_wake(stop_wake), .vector_fetch(hold[5]),
    .internal_reset(hold[0]), .monitor_mode(hold[4]), .break_active(hold[3]),
    .rst_pin_test_voltage(hold[2]), .irq_pin_test_voltage(hold[1]), .lvm_trip(lvm_trip),
    .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .system_reset(system_reset),
    .lvm_power(lvm_power), .lvm_reset(lvm_reset), .illegal_opcode(illegal_opcode),
    .stop_active(stop_active)
  );

  // Clock at 100 MHz
  always #5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // A bounded wait ran out: count it and close the run
  task automatic give_up();
    n_errors++;
    $display("mismatch at %0t: wait ran out", $time);
    print_verdict();
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // One APB transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) give_up();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
  endtask

  // Edges until the reset pin driver turns on; above lim if it never does
  task automatic wait_fire(input int lim, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rst_pin_oe !== 1'b1 && n <= lim);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    int n;
    do_reset();
    apb(1'b0, ADDR_CONFIG, 8'h00);
    chk(r, {24'h0, CFG_RESET_VAL}, "config after reset");
    apb(1'b1, ADDR_CONFIG, 8'h01);
    apb(1'b1, ADDR_CONFIG, 8'h00);
    apb(1'b0, ADDR_CONFIG, 8'h00);
    chk(r, 32'h1, "second config write");
    apb(1'b0, ADDR_SERVICE, 8'h00);
    chk({e, r[7:0]}, {1'b0, RESET_VECTOR_LO}, "service read");
    apb(1'b0, 18'h00100, 8'h00);
    chk(e, 1'b1, "unmapped access");
    // Disabled watchdog must stay quiet past a whole period
    wait_fire(PER + 100, n);
    chk(n > PER + 100, 1'b1, "disabled watchdog fired");
    $display("test regs done");
  endtask

  task automatic t_timeout();
    int n;
    do_reset();
    // Services spaced under one period keep it quiet past the first expiry
    repeat (2) begin
      repeat (1500) @(posedge pclk);
      apb(1'b1, ADDR_SERVICE, 8'h5a);
    end
    apb(1'b0, ADDR_STATUS, 8'h00);
    chk(r[STS_WDG_FLAG], 1'b0, "serviced watchdog fired");
    repeat (1500) @(posedge pclk);
    apb(1'b1, ADDR_SERVICE, 8'ha5);
    wait_fire(PER + 100, n);
    chk(n >= PER - 10 && n <= PER + 3, 1'b1, "timeout period");
    chk(system_reset, 1'b1, "system reset on expiry");
    n = 0;
    while (rst_pin_oe === 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk(n, 32, "reset pulse length");
    chk(rst_pin_o, 1'b0, "reset pin level");
    apb(1'b0, ADDR_STATUS, 8'h00);
    chk(r[STS_WDG_FLAG], 1'b1, "watchdog flag");
    apb(1'b0, ADDR_STATUS, 8'h00);
    chk(r[STS_WDG_FLAG], 1'b0, "flag cleared by read");
    $display("test timeout done");
  endtask

  task automatic t_stop(input logic [7:0] cfg);
    int n;
    int exp;
    do_reset();
    apb(1'b1, ADDR_CONFIG, cfg);
    @(posedge pclk);
    lvm_trip <= 1'b1;
    chk(lvm_power, cfg[CFG_LVM_POWER], "monitor power");
    @(posedge pclk);
    chk(lvm_reset, cfg[CFG_LVM_POWER] & cfg[CFG_LVM_RESET], "monitor reset gate");
    lvm_trip <= 1'b0;
    stop_instr <= 1'b1;
    @(posedge pclk);
    chk(illegal_opcode, !cfg[CFG_STOP_ENABLE], "illegal stop");
    stop_instr <= 1'b0;
    @(posedge pclk);
    chk(stop_active, cfg[CFG_STOP_ENABLE], "stop entry");
    chk(lvm_power, cfg[CFG_LVM_POWER] & (cfg[CFG_LVM_STOP] | !cfg[CFG_STOP_ENABLE]), "power in stop");
    if (cfg[CFG_STOP_ENABLE]) begin
      wait_fire(PER + 100, n);
      chk(n > PER + 100, 1'b1, "fired while stopped");
      stop_wake <= 1'b1;
      @(posedge pclk);
      stop_wake <= 1'b0;
      n = 1;
      while (stop_active === 1'b1 && n < 5000) begin
        @(posedge pclk);
        n++;
      end
      exp = cfg[CFG_SHORT_RECOV] ? RECOV_SHORT_CYC : RECOV_LONG_CYC;
      chk(n >= exp - 3 && n <= exp + 3, 1'b1, "stop recovery delay");
    end
    $display("test stop %h done", cfg);
  endtask

  // Test voltage, internal reset and a held vector fetch keep it quiet; break with irq only does not
  task automatic t_hold();
    int n;
    logic [5:0] cases [6] = '{6'b010100, 6'b010010, 6'b001100, 6'b000001, 6'b100000, 6'b001010};
    for (int i = 0; i < 6; i++) begin
      do_reset();
      hold <= cases[i];
      wait_fire(PER + 100, n);
      chk(n > PER + 100, i < 5, "hold off");
      hold <= '0;
    end
    $display("test hold done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    t_regs();
    t_timeout();
    t_stop(8'h1a);
    t_stop(8'h72);
    t_stop(8'h00);
    t_hold();
    print_verdict();
  end

  // Cuts a hang short well inside the cycle budget
  initial begin
    repeat (100000) @(posedge pclk);
    give_up();
  end
endmodule
`default_nettype wire
